// >>> src/idt_consts.svh
// Opcode encodings, lengths and cycle counts for the instruction decoder
`ifndef IDT_CONSTS_SVH
`define IDT_CONSTS_SVH
`define IDT_CYC_W         6
`define IDT_LEN1          2'd1
`define IDT_LEN2          2'd2
`define IDT_LEN3          2'd3
`define IDT_CYC2          6'd2
`define IDT_CYC4          6'd4
`define IDT_CYC8          6'd8
`define IDT_CYC16         6'd16
`define IDT_CYC32         6'd32
`define IDT_ROW_INC       4'h0
`define IDT_ROW_DEC       4'h1
`define IDT_ROW_ADD       4'h2
`define IDT_ROW_ADDC      4'h3
`define IDT_ROW_ORL       4'h4
`define IDT_ROW_ANL       4'h5
`define IDT_ROW_XRL       4'h6
`define IDT_ROW_MOVI      4'h7
`define IDT_ROW_MOVD      4'h8
`define IDT_ROW_SUBB      4'h9
`define IDT_ROW_MOVR      4'ha
`define IDT_ROW_XCH       4'hc
`define IDT_ROW_MOVA      4'he
`define IDT_ROW_MOVF      4'hf
`define IDT_LO_IMM        4'h4
`define IDT_LO_DIR        4'h5
`define IDT_IND_PFX       3'h3
`define IDT_OPC_RR        8'h03
`define IDT_OPC_INC_A     8'h04
`define IDT_OPC_RRC       8'h13
`define IDT_OPC_DEC_A     8'h14
`define IDT_OPC_RL        8'h23
`define IDT_OPC_RLC       8'h33
`define IDT_OPC_ORL_DA    8'h42
`define IDT_OPC_ORL_DI    8'h43
`define IDT_OPC_ANL_DA    8'h52
`define IDT_OPC_ANL_DI    8'h53
`define IDT_OPC_XRL_DA    8'h62
`define IDT_OPC_XRL_DI    8'h63
`define IDT_OPC_MOV_DI    8'h75
`define IDT_OPC_MOVC_PC   8'h83
`define IDT_OPC_DIV       8'h84
`define IDT_OPC_MOV_DD    8'h85
`define IDT_OPC_MOV_DP    8'h90
`define IDT_OPC_MOVC_DP   8'h93
`define IDT_OPC_INC_DP    8'ha3
`define IDT_OPC_MUL       8'ha4
`define IDT_OPC_RSVD      8'ha5
`define IDT_OPC_PUSH      8'hc0
`define IDT_OPC_SWAP      8'hc4
`define IDT_OPC_POP       8'hd0
`define IDT_OPC_DA        8'hd4
`define IDT_OPC_MOVX_RD16 8'he0
`define IDT_OPC_CLR       8'he4
`define IDT_OPC_MOVX_WR16 8'hf0
`define IDT_OPC_CPL       8'hf4
`define IDT_PFX_XCHD      7'h6b
`define IDT_PFX_MOVX_RD8  7'h71
`define IDT_PFX_MOVX_WR8  7'h79
`endif

// >>> src/idt_pkg.sv
// Types shared by the instruction decoder modules
package idt_pkg;
  typedef enum logic [4:0] {
    OP_OTHER, OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC, OP_INC_DP, OP_MUL, OP_DIV, OP_DA,
    OP_ANL, OP_ORL, OP_XRL, OP_CLR, OP_CPL, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC,
    OP_MOV, OP_MOV_DP, OP_MOVC_DP, OP_MOVC_PC, OP_MOVX_RD8, OP_MOVX_RD16, OP_MOVX_WR8,
    OP_MOVX_WR16, OP_PUSH, OP_POP, OP_XCH, OP_XCHD
  } idt_op_t;
  typedef enum logic [2:0] {
    AM_NONE, AM_ACC, AM_BANK, AM_IND, AM_DIR, AM_IMM, AM_DIR_IMM
  } idt_amode_t;
endpackage : idt_pkg

// >>> src/idt_op_table.sv
// Opcode lookup: operation, operand mode, length and cycle count
`timescale 1ns/10ps
`default_nettype none
`include "idt_consts.svh"
module idt_op_table import idt_pkg::*; (
  // Opcode and width mode
  input  wire logic [7:0]            opcode,
  input  wire logic                  muldiv16,
  input  wire logic                  div32,
  // Decoded fields
  output idt_op_t                    op,
  output idt_amode_t                 amode,
  output logic [1:0]                 len,
  output logic [`IDT_CYC_W-1:0]      cyc
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    op    = OP_OTHER;
    amode = AM_NONE;
    len   = `IDT_LEN1;
    cyc   = `IDT_CYC2;
    // ------------------------------------------------------------
    // Register-row groups
    // ------------------------------------------------------------
    if (lo >= `IDT_LO_IMM) begin
      case (hi)
        `IDT_ROW_INC:  op = OP_INC;
        `IDT_ROW_DEC:  op = OP_DEC;
        `IDT_ROW_ADD:  op = OP_ADD;
        `IDT_ROW_ADDC: op = OP_ADDC;
        `IDT_ROW_SUBB: op = OP_SUBB;
        `IDT_ROW_ANL:  op = OP_ANL;
        `IDT_ROW_ORL:  op = OP_ORL;
        `IDT_ROW_XRL:  op = OP_XRL;
        `IDT_ROW_XCH:  op = OP_XCH;
        `IDT_ROW_MOVI, `IDT_ROW_MOVD, `IDT_ROW_MOVR, `IDT_ROW_MOVA, `IDT_ROW_MOVF: op = OP_MOV;
        default:       op = OP_OTHER;
      endcase
      if (op != OP_OTHER) begin
        if (lo[3]) begin
          amode = AM_BANK;
        end else if (lo[3:1] == `IDT_IND_PFX) begin
          amode = AM_IND;
        end else if (lo == `IDT_LO_DIR) begin
          amode = AM_DIR;
          len   = `IDT_LEN2;
        end else begin
          amode = AM_IMM;
          len   = `IDT_LEN2;
        end
        if (hi == `IDT_ROW_MOVD || hi == `IDT_ROW_MOVR) begin
          len = (lo == `IDT_LO_DIR) ? `IDT_LEN3 : `IDT_LEN2;
          cyc = `IDT_CYC4;
        end
        if (hi == `IDT_ROW_MOVI && amode != AM_IMM) begin
          len = `IDT_LEN2;
        end
      end
    end
    // ------------------------------------------------------------
    // Single opcodes
    // ------------------------------------------------------------
    case (opcode)
      `IDT_OPC_RR:      op = OP_RR;
      `IDT_OPC_RRC:     op = OP_RRC;
      `IDT_OPC_RL:      op = OP_RL;
      `IDT_OPC_RLC:     op = OP_RLC;
      `IDT_OPC_INC_A, `IDT_OPC_DEC_A, `IDT_OPC_SWAP, `IDT_OPC_CLR, `IDT_OPC_CPL, `IDT_OPC_DA: begin
        amode = AM_ACC;
        len   = `IDT_LEN1;
        if (opcode == `IDT_OPC_SWAP) op = OP_SWAP;
        if (opcode == `IDT_OPC_CLR) op = OP_CLR;
        if (opcode == `IDT_OPC_CPL) op = OP_CPL;
        if (opcode == `IDT_OPC_DA) op = OP_DA;
      end
      `IDT_OPC_ORL_DA, `IDT_OPC_ANL_DA, `IDT_OPC_XRL_DA: begin
        amode = AM_DIR;
        len   = `IDT_LEN2;
        op    = (hi == `IDT_ROW_ORL) ? OP_ORL : (hi == `IDT_ROW_ANL) ? OP_ANL : OP_XRL;
      end
      `IDT_OPC_ORL_DI, `IDT_OPC_ANL_DI, `IDT_OPC_XRL_DI, `IDT_OPC_MOV_DI: begin
        amode = AM_DIR_IMM;
        len   = `IDT_LEN3;
        cyc   = `IDT_CYC4;
        op    = (hi == `IDT_ROW_ORL) ? OP_ORL : (hi == `IDT_ROW_ANL) ? OP_ANL :
                (hi == `IDT_ROW_XRL) ? OP_XRL : OP_MOV;
      end
      `IDT_OPC_MOVC_PC: begin op = OP_MOVC_PC; cyc = `IDT_CYC8; end
      `IDT_OPC_MOVC_DP: begin op = OP_MOVC_DP; cyc = `IDT_CYC8; end
      `IDT_OPC_DIV: begin
        op    = OP_DIV;
        amode = AM_NONE;
        len   = `IDT_LEN1;
        cyc   = !muldiv16 ? `IDT_CYC8 : (div32 ? `IDT_CYC32 : `IDT_CYC16);
      end
      `IDT_OPC_MUL: begin
        op    = OP_MUL;
        amode = AM_NONE;
        len   = `IDT_LEN1;
        cyc   = muldiv16 ? `IDT_CYC16 : `IDT_CYC8;
      end
      `IDT_OPC_RSVD: begin
        op    = OP_OTHER;
        amode = AM_NONE;
        len   = `IDT_LEN1;
        cyc   = `IDT_CYC2;
      end
      `IDT_OPC_MOV_DP: begin op = OP_MOV_DP; amode = AM_IMM; len = `IDT_LEN3; cyc = `IDT_CYC4; end
      `IDT_OPC_INC_DP: begin op = OP_INC_DP; cyc = `IDT_CYC4; end
      `IDT_OPC_PUSH, `IDT_OPC_POP: begin
        op    = (opcode == `IDT_OPC_PUSH) ? OP_PUSH : OP_POP;
        amode = AM_DIR;
        len   = `IDT_LEN2;
        cyc   = `IDT_CYC4;
      end
      `IDT_OPC_MOVX_RD16: begin op = OP_MOVX_RD16; cyc = `IDT_CYC8; end
      `IDT_OPC_MOVX_WR16: begin op = OP_MOVX_WR16; cyc = `IDT_CYC8; end
      default: begin
        if (opcode[7:1] == `IDT_PFX_XCHD) begin
          op    = OP_XCHD;
          amode = AM_IND;
        end else if (opcode[7:1] == `IDT_PFX_MOVX_RD8 || opcode[7:1] == `IDT_PFX_MOVX_WR8) begin
          op    = (opcode[4]) ? OP_MOVX_WR8 : OP_MOVX_RD8;
          amode = AM_IND;
          cyc   = `IDT_CYC8;
        end
      end
    endcase
  end
endmodule : idt_op_table
`default_nettype wire

// >>> src/idt_decoder.sv
// Instruction fetch sequencing, decode capture and execution timing
`timescale 1ns/10ps
`default_nettype none
`include "idt_consts.svh"
module idt_decoder import idt_pkg::*; (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Code byte stream
  input  wire logic [7:0]            code_byte,
  input  wire logic                  code_valid,
  output logic                       code_ready,
  // Multiply and divide width mode
  input  wire logic                  muldiv16,
  input  wire logic                  div32,
  // Decoded instruction
  output logic                       instr_done,
  output logic                       decode_busy,
  output logic [7:0]                 instr_opcode_ff,
  output logic [7:0]                 instr_operand1_ff,
  output logic [7:0]                 instr_operand2_ff,
  output logic [1:0]                 instr_len_ff,
  output logic [`IDT_CYC_W-1:0]      instr_cycles_ff,
  output idt_op_t                    instr_op_ff,
  output idt_amode_t                 instr_amode_ff,
  output logic [2:0]                 bank_register_ff,
  output logic                       indirect_pointer_register_ff
);
  typedef enum logic [1:0] {S_OPC, S_OPND, S_WAIT} idt_state_t;

  idt_state_t                state_ff;
  idt_state_t                nxt_state;
  logic [1:0]                need_ff;
  logic [`IDT_CYC_W-1:0]     cnt_ff;
  logic                      opc_take;
  logic                      opnd_take;
  idt_op_t                   tbl_op;
  idt_amode_t                tbl_amode;
  logic [1:0]                tbl_len;
  logic [`IDT_CYC_W-1:0]     tbl_cyc;

  // ------------------------------------------------------------
  // Opcode lookup
  // ------------------------------------------------------------
  idt_op_table u_table (
    .opcode   (code_byte),
    .muldiv16 (muldiv16),
    .div32    (div32),
    .op       (tbl_op),
    .amode    (tbl_amode),
    .len      (tbl_len),
    .cyc      (tbl_cyc)
  );

  // ------------------------------------------------------------
  // Handshake and completion
  // ------------------------------------------------------------
  assign code_ready  = (state_ff == S_OPC) || (state_ff == S_OPND);
  assign opc_take    = code_valid && (state_ff == S_OPC);
  assign opnd_take   = code_valid && (state_ff == S_OPND);
  assign decode_busy = (state_ff != S_OPC);
  assign instr_done  = (cnt_ff == '0) &&
                       ((state_ff == S_WAIT) || (opnd_take && need_ff == 2'd1));

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_OPC:   if (opc_take) nxt_state = (tbl_len == `IDT_LEN1) ? S_WAIT : S_OPND;
      S_OPND:  if (opnd_take && need_ff == 2'd1) nxt_state = instr_done ? S_OPC : S_WAIT;
      S_WAIT:  if (instr_done) nxt_state = S_OPC;
      default: nxt_state = S_OPC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_ff <= S_OPC;
    else        state_ff <= nxt_state;
  end

  // Operand bytes still owed
  always_ff @(posedge clk) begin
    if (!rst_n)         need_ff <= 2'd0;
    else if (opc_take)  need_ff <= tbl_len - 2'd1;
    else if (opnd_take) need_ff <= need_ff - 2'd1;
  end

  // Execution cycle counter, counts down from the opcode fetch whether or not operands have arrived, then stops at zero
  always_ff @(posedge clk) begin
    if (!rst_n)              cnt_ff <= '0;
    else if (opc_take)       cnt_ff <= tbl_cyc - `IDT_CYC2;
    else if (cnt_ff != '0)   cnt_ff <= cnt_ff - 1'b1;
  end

  // ------------------------------------------------------------
  // Decode capture
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_opcode_ff              <= 8'h00;
      instr_len_ff                 <= `IDT_LEN1;
      instr_cycles_ff              <= `IDT_CYC2;
      instr_op_ff                  <= OP_OTHER;
      instr_amode_ff               <= AM_NONE;
      bank_register_ff             <= 3'h0;
      indirect_pointer_register_ff <= 1'b0;
    end else if (opc_take) begin
      instr_opcode_ff              <= code_byte;
      instr_len_ff                 <= tbl_len;
      instr_cycles_ff              <= tbl_cyc;
      instr_op_ff                  <= tbl_op;
      instr_amode_ff               <= tbl_amode;
      bank_register_ff             <= code_byte[2:0];
      indirect_pointer_register_ff <= code_byte[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || opc_take) begin
      instr_operand1_ff <= 8'h00;
      instr_operand2_ff <= 8'h00;
    end else if (opnd_take) begin
      if (instr_len_ff - need_ff == 2'd1) instr_operand1_ff <= code_byte;
      else                                instr_operand2_ff <= code_byte;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_len_range;
    instr_done |-> (instr_len_ff >= `IDT_LEN1) && (instr_len_ff <= `IDT_LEN3);
  endproperty
  a_len_range: assert property (p_len_range) else $error("Length out of range");

  property p_opnd_count;
    opc_take |=> (need_ff == $past(tbl_len) - 2'd1);
  endproperty
  a_opnd_count: assert property (p_opnd_count) else $error("Operand count wrong");

  property p_cyc_range;
    instr_done |-> (instr_cycles_ff >= `IDT_CYC2) && (instr_cycles_ff <= `IDT_CYC32);
  endproperty
  a_cyc_range: assert property (p_cyc_range) else $error("Cycle count out of range");

  property p_two_cycle;
    (opc_take && tbl_len == `IDT_LEN1 && tbl_cyc == `IDT_CYC2) |=> instr_done;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("Two-clock instruction late");

  property p_add_bank;
    (opc_take && code_byte[7:3] == 5'h05) |-> tbl_op == OP_ADD && tbl_amode == AM_BANK && tbl_cyc == `IDT_CYC2;
  endproperty
  a_add_bank: assert property (p_add_bank) else $error("Add bank decode wrong");

  property p_addc_imm;
    (opc_take && code_byte == 8'h34) |-> tbl_op == OP_ADDC && tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC2;
  endproperty
  a_addc_imm: assert property (p_addc_imm) else $error("Add carry immediate wrong");

  property p_subb_ind;
    (opc_take && code_byte[7:1] == 7'h4b) |-> tbl_op == OP_SUBB && tbl_amode == AM_IND && tbl_len == `IDT_LEN1;
  endproperty
  a_subb_ind: assert property (p_subb_ind) else $error("Subtract indirect wrong");

  property p_anl_dir;
    (opc_take && code_byte == `IDT_OPC_ANL_DI) |-> tbl_op == OP_ANL && tbl_len == `IDT_LEN3 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_anl_dir: assert property (p_anl_dir) else $error("AND direct immediate wrong");

  property p_xrl_dir;
    (opc_take && code_byte == `IDT_OPC_XRL_DA) |-> tbl_op == OP_XRL && tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC2;
  endproperty
  a_xrl_dir: assert property (p_xrl_dir) else $error("XOR direct wrong");

  property p_rotate;
    (opc_take && code_byte[3:0] == 4'h3 && code_byte[7:6] == 2'h0) |-> tbl_len == `IDT_LEN1 && tbl_cyc == `IDT_CYC2;
  endproperty
  a_rotate: assert property (p_rotate) else $error("Rotate timing wrong");

  property p_mov_bank_dir;
    (opc_take && code_byte[7:3] == 5'h15) |-> tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_mov_bank_dir: assert property (p_mov_bank_dir) else $error("Bank load timing wrong");

  property p_mov_dd;
    (opc_take && code_byte == `IDT_OPC_MOV_DD) |-> tbl_len == `IDT_LEN3 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_mov_dd: assert property (p_mov_dd) else $error("Direct copy timing wrong");

  property p_eight_cycle;
    (opc_take && tbl_len == `IDT_LEN1 && tbl_cyc == `IDT_CYC8) |=> !instr_done [*6] ##1 instr_done;
  endproperty
  a_eight_cycle: assert property (p_eight_cycle) else $error("Eight-clock timing wrong");

  property p_movx;
    (opc_take && code_byte[7:5] == 3'h7 && code_byte[3:2] == 2'h0 && code_byte[1:0] != 2'h1)
      |-> tbl_len == `IDT_LEN1 && tbl_cyc == `IDT_CYC8;
  endproperty
  a_movx: assert property (p_movx) else $error("External access timing wrong");

  property p_stack;
    (opc_take && (code_byte == `IDT_OPC_PUSH || code_byte == `IDT_OPC_POP))
      |-> tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_stack: assert property (p_stack) else $error("Stack timing wrong");

  property p_xchd;
    (opc_take && code_byte[7:1] == `IDT_PFX_XCHD) |-> tbl_op == OP_XCHD && tbl_cyc == `IDT_CYC2;
  endproperty
  a_xchd: assert property (p_xchd) else $error("Nibble exchange wrong");

  property p_bank_idx;
    (instr_done && instr_amode_ff == AM_BANK) |-> instr_opcode_ff[3] && bank_register_ff == instr_opcode_ff[2:0];
  endproperty
  a_bank_idx: assert property (p_bank_idx) else $error("Bank register index wrong");

  property p_four_cycle;
    (opc_take && code_byte == `IDT_OPC_INC_DP) |=> !instr_done [*2] ##1 instr_done;
  endproperty
  a_four_cycle: assert property (p_four_cycle) else $error("Pointer increment timing wrong");

  property p_div32;
    (opc_take && code_byte == `IDT_OPC_DIV && muldiv16 && div32) |-> tbl_cyc == `IDT_CYC32;
  endproperty
  a_div32: assert property (p_div32) else $error("Wide divide timing wrong");

  property p_mul8;
    (opc_take && code_byte == `IDT_OPC_MUL && !muldiv16) |-> tbl_cyc == `IDT_CYC8;
  endproperty
  a_mul8: assert property (p_mul8) else $error("Narrow multiply timing wrong");

  property p_anl_acc;
    (opc_take && code_byte[7:4] == 4'h5 && code_byte[3:0] >= 4'h4)
      |-> tbl_op == OP_ANL && tbl_cyc == `IDT_CYC2;
  endproperty
  a_anl_acc: assert property (p_anl_acc) else $error("AND into accumulator wrong");

  property p_orl_dir_imm;
    (opc_take && code_byte == `IDT_OPC_ORL_DI)
      |-> tbl_op == OP_ORL && tbl_len == `IDT_LEN3 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_orl_dir_imm: assert property (p_orl_dir_imm) else $error("OR direct immediate wrong");

  property p_mov_dir_bank;
    (opc_take && code_byte[7:3] == 5'h11)
      |-> tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_mov_dir_bank: assert property (p_mov_dir_bank) else $error("Bank store timing wrong");

  property p_mov_dp;
    (opc_take && code_byte == `IDT_OPC_MOV_DP)
      |-> tbl_op == OP_MOV_DP && tbl_len == `IDT_LEN3 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_mov_dp: assert property (p_mov_dp) else $error("Pointer load timing wrong");

  property p_mov_ind_imm;
    (opc_take && code_byte[7:1] == 7'h3b)
      |-> tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC2;
  endproperty
  a_mov_ind_imm: assert property (p_mov_ind_imm) else $error("Indirect immediate store wrong");

  property p_mov_ind_dir;
    (opc_take && code_byte[7:1] == 7'h53)
      |-> tbl_len == `IDT_LEN2 && tbl_cyc == `IDT_CYC4;
  endproperty
  a_mov_ind_dir: assert property (p_mov_ind_dir) else $error("Indirect direct store wrong");

  property p_movx16;
    (opc_take && (code_byte == `IDT_OPC_MOVX_RD16 || code_byte == `IDT_OPC_MOVX_WR16))
      |-> tbl_len == `IDT_LEN1 && tbl_cyc == `IDT_CYC8 && (tbl_op == OP_MOVX_RD16 || tbl_op == OP_MOVX_WR16);
  endproperty
  a_movx16: assert property (p_movx16) else $error("Wide external access wrong");

  property p_xch;
    (opc_take && code_byte[7:4] == 4'hc && code_byte[3:0] >= 4'h5)
      |-> tbl_op == OP_XCH && tbl_cyc == `IDT_CYC2;
  endproperty
  a_xch: assert property (p_xch) else $error("Exchange decode wrong");

  property p_inc_dec;
    (opc_take && code_byte[7:5] == 3'h0 && code_byte[3:0] >= 4'h4)
      |-> tbl_cyc == `IDT_CYC2 && (tbl_op == OP_INC || tbl_op == OP_DEC);
  endproperty
  a_inc_dec: assert property (p_inc_dec) else $error("Increment or decrement wrong");

  property p_done_pulse;
    instr_done |=> !instr_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("Done pulse too long");
endmodule : idt_decoder
`default_nettype wire

// >>> dv/cpu_instruction_decode_timing_bench.sv
// Self-checking bench for the instruction decoder timing
`timescale 1ns/10ps
`default_nettype none
`include "idt_consts.svh"
module cpu_instruction_decode_timing_bench import idt_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  clk;
  logic                  rst_n;
  logic [7:0]            code_byte;
  logic                  code_valid;
  logic                  code_ready;
  logic                  muldiv16;
  logic                  div32;
  logic                  instr_done;
  logic                  decode_busy;
  logic [7:0]            opc_q, opr1_q, opr2_q;
  logic [1:0]            len_q;
  logic [`IDT_CYC_W-1:0] cyc_q;
  idt_op_t               op_q;
  idt_amode_t            am_q;
  logic [2:0]            bank_q;
  logic                  ind_q;
  int                    bad_count, checked, cyc, took;
  int                    done_q[$];
  logic [7:0]            vq[$];
  logic [31:0]           lfsr;

  idt_decoder idt_decoder_i (.clk(clk), .rst_n(rst_n), .code_byte(code_byte), .code_valid(code_valid),
    .code_ready(code_ready), .muldiv16(muldiv16), .div32(div32), .instr_done(instr_done),
    .decode_busy(decode_busy), .instr_opcode_ff(opc_q), .instr_operand1_ff(opr1_q),
    .instr_operand2_ff(opr2_q), .instr_len_ff(len_q), .instr_cycles_ff(cyc_q), .instr_op_ff(op_q),
    .instr_amode_ff(am_q), .bank_register_ff(bank_q), .indirect_pointer_register_ff(ind_q));

  // ----------------------------------------
  // Clock, cycle count, done monitor
  // ----------------------------------------
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) if (instr_done === 1'b1) done_q.push_back(cyc);

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  function automatic void model(input logic [7:0] o, input logic m, input logic d,
                                output bit ok, output int l, output int c);
    logic [3:0] h, lo;
    h = o[7:4];
    lo = o[3:0];
    ok = 1;
    l = 1;
    c = 2;
    if (lo >= 4'h6) begin
      ok = (h != 4'hb) && !(lo >= 4'h8 && h == 4'hd);
      if (h == 4'ha || h == 4'h8) begin l = 2; c = 4; end
      if (h == 4'h7) l = 2;
    end else if (lo == 4'h5) begin
      ok = h != 4'ha && h != 4'hb && h != 4'hd;
      l = 2;
      if (h == 4'h7 || h == 4'h8) begin l = 3; c = 4; end
    end else if (lo == 4'h4) begin
      ok = h != 4'hb;
      if (h inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9}) l = 2;
      if (o == 8'ha4) c = m ? 16 : 8;
      if (o == 8'h84) c = !m ? 8 : (d ? 32 : 16);
    end else case (o)
      8'h03, 8'h13, 8'h23, 8'h33: c = 2;
      8'h42, 8'h52, 8'h62: l = 2;
      8'h43, 8'h53, 8'h63, 8'h90: begin l = 3; c = 4; end
      8'h83, 8'h93, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: c = 8;
      8'ha3: c = 4;
      8'hc0, 8'hd0: begin l = 2; c = 4; end
      default: ok = 0;
    endcase
  endfunction : model

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    code_byte <= b;
    code_valid <= 1'b1;
    @(negedge clk);
    while (code_ready !== 1'b1 && n < 64) begin @(negedge clk); n++; end
    took = cyc;
    @(posedge clk);
  endtask : send

  task automatic run_instr(input logic [7:0] o, input int gap);
    bit ok;
    int l, c, t0, tl, td, n;
    logic [7:0] b1, b2;
    lfsr = nxt(lfsr);
    b1 = lfsr[7:0];
    b2 = lfsr[15:8];
    done_q.delete();
    send(o);
    t0 = took;
    model(o, muldiv16, div32, ok, l, c);
    if (l > 1) begin
      if (gap > 0) begin
        code_valid <= 1'b0;
        code_byte <= ~o;
        repeat (gap) @(posedge clk);
      end
      send(b1);
      if (l > 2) send(b2);
    end
    tl = took;
    code_valid <= 1'b0;
    code_byte <= ~b1;
    @(negedge clk);
    chk("ready", (c - 1 > tl - t0) ? 0 : 1, code_ready);
    n = 0;
    while (done_q.size() == 0 && n < 64) begin @(negedge clk); n++; end
    td = (done_q.size() > 0) ? done_q[0] - t0 : -1;
    chk("done cycle", (c - 1 > tl - t0) ? c - 1 : tl - t0, td);
    @(negedge clk);
    chk("done count", 1, done_q.size());
    chk("busy after", 0, decode_busy);
    chk("opcode", o, opc_q);
    chk("length", l, len_q);
    chk("cycles", c, cyc_q);
    chk("operand1", (l > 1) ? b1 : 8'h00, opr1_q);
    chk("operand2", (l > 2) ? b2 : 8'h00, opr2_q);
    chk("bank reg", o[2:0], bank_q);
    chk("ind reg", o[0], ind_q);
    if (o[3]) chk("mode", AM_BANK, am_q);
    if (o[3:1] == 3'h3) chk("mode", AM_IND, am_q);
    if (o[3:0] >= 4'h4) begin
      case (o[7:4])
        4'h2:    chk("operation", OP_ADD, op_q);
        4'h3:    chk("operation", OP_ADDC, op_q);
        4'h9:    chk("operation", OP_SUBB, op_q);
        4'h5:    chk("operation", OP_ANL, op_q);
        4'h4:    chk("operation", OP_ORL, op_q);
        4'h6:    chk("operation", OP_XRL, op_q);
        4'hc:    if (o[3:0] != 4'h4) chk("operation", OP_XCH, op_q);
        4'hd:    if (o[3:1] == 3'h3) chk("operation", OP_XCHD, op_q);
        default: ;
      endcase
    end
    @(posedge clk);
  endtask : run_instr

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bit ok;
    int l, c;
    rst_n = 1'b0;
    code_valid = 1'b0;
    code_byte = 8'h00;
    muldiv16 = 1'b0;
    div32 = 1'b0;
    cyc = 0;
    lfsr = 32'h0001_4733;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("reset ready", 1, code_ready);
    chk("reset done", 0, instr_done);
    chk("reset op", OP_OTHER, op_q);
    chk("reset mode", AM_NONE, am_q);
    chk("reset len", 1, len_q);
    chk("reset cycles", 2, cyc_q);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      model(i[7:0], 1'b0, 1'b0, ok, l, c);
      if (ok) begin
        vq.push_back(i[7:0]);
        run_instr(i[7:0], 0);
      end
    end
    for (int k = 0; k < 3; k++) begin
      muldiv16 <= (k > 0);
      div32 <= (k == 2);
      run_instr(8'ha4, 0);
      run_instr(8'h84, 0);
    end
    repeat (120) begin
      lfsr = nxt(lfsr);
      muldiv16 <= lfsr[20];
      div32 <= lfsr[21];
      run_instr(vq[lfsr[15:0] % vq.size()], lfsr[9:8] % 3);
    end
    print_verdict();
  end
endmodule : cpu_instruction_decode_timing_bench
`default_nettype wire
